// [core/display_ram_remap_map.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Frame memory is 128 columns by 128 rows of 18-bit pixels.
// - Pixel holds sub-pixels A, B, C of six bits, bit 5 most significant.
// - Column and row order each reversible; reversed address n shows at 127 minus n.
// - Stored pixels reach the column segments one row at a time, while that row's common drive is on.
// - Host bus 8, 16 or 18 bits wide; unused upper lines ignored.
module display_ram_remap_map (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire display_ram_pkg::host_pins_t i_host,
	input wire display_ram_pkg::bus_width_t i_bus_width,
	input wire logic i_seg_remap,
	input wire logic i_com_remap,
	output logic [17:0] o_data,
	output logic o_data_oe,
	output logic [display_ram_pkg::ROWS-1:0] o_row_drive,
	output display_ram_pkg::seg_row_t o_seg_drive
);
	import display_ram_pkg::*;

	host_state_t st;
	host_state_t next_st;
	seg_row_t display_frame_ram [ROWS];
	logic ram_we;
	pixel_t ram_wdata;
	pixel_t rd_pix;
	logic wr_edge;
	logic rd_fall;
	logic rd_rise;
	logic [17:0] d;
	logic [6:0] scan_ram_row;
	seg_row_t scan_row;

	function automatic logic [13:0] step_addr(input logic [6:0] row, input logic [6:0] col);
		if (col == ADDR_MAX) begin
			step_addr = {row + ADDR_ONE, ADDR_ZERO};
		end else begin
			step_addr = {row, col + ADDR_ONE};
		end
	endfunction

	// ==========================================================
	// Host strobes, taken from the second synchroniser stage
	assign d = st.sync2.data;
	assign wr_edge = !st.prev_wr_n && st.sync2.wr_n && !st.sync2.cs_n;
	assign rd_fall = st.prev_rd_n && !st.sync2.rd_n && !st.sync2.cs_n && st.sync2.dc;
	assign rd_rise = !st.prev_rd_n && st.sync2.rd_n && !st.sync2.cs_n && st.sync2.dc;
	assign rd_pix = display_frame_ram[st.row][st.col];

	always_comb begin
		next_st = st;
		ram_we = 1'b0;
		ram_wdata = '0;
		next_st.sync1 = i_host;
		next_st.sync2 = st.sync1;
		next_st.prev_wr_n = st.sync2.wr_n;
		next_st.prev_rd_n = st.sync2.rd_n;
		next_st.seg_remap = i_seg_remap;
		next_st.com_remap = i_com_remap;
		// Drive only for data reads; status reads are not supported
		next_st.oe = !st.sync2.cs_n && !st.sync2.rd_n && st.sync2.dc;
		if (wr_edge && !st.sync2.dc) begin
			// Own tiny command set: bit 7 picks row or column pointer
			if (d[CMD_ROW_BIT]) begin
				next_st.row = d[6:0];
			end else begin
				next_st.col = d[6:0];
			end
			next_st.phase = PHASE_ZERO;
		end else if (wr_edge) begin
			unique case (i_bus_width)
				BUS_W18: begin
					ram_wdata = d;
				end
				BUS_W16: begin
					if (st.phase == PHASE_ZERO) begin
						next_st.hold.a = d[11:6];
						next_st.hold.b = d[5:0];
					end else begin
						ram_wdata = {st.hold.a, st.hold.b, d[5:0]};
					end
				end
				default: begin
					if (st.phase == PHASE_ZERO) begin
						next_st.hold.a = d[5:0];
					end else if (st.phase == PHASE_ONE) begin
						next_st.hold.b = d[5:0];
					end else begin
						ram_wdata = {st.hold.a, st.hold.b, d[5:0]};
					end
				end
			endcase
			if (st.phase == last_phase(i_bus_width)) begin
				ram_we = 1'b1;
				next_st.phase = PHASE_ZERO;
				{next_st.row, next_st.col} = step_addr(st.row, st.col);
			end else begin
				next_st.phase = st.phase + PHASE_ONE;
			end
		end
		if (rd_fall) begin
			unique case (i_bus_width)
				BUS_W18: next_st.rd_data = rd_pix;
				BUS_W16: begin
					if (st.phase == PHASE_ZERO) begin
						next_st.rd_data = {6'h00, rd_pix.a, rd_pix.b};
					end else begin
						next_st.rd_data = {12'h000, rd_pix.c};
					end
				end
				default: begin
					if (st.phase == PHASE_ZERO) begin
						next_st.rd_data = {12'h000, rd_pix.a};
					end else if (st.phase == PHASE_ONE) begin
						next_st.rd_data = {12'h000, rd_pix.b};
					end else begin
						next_st.rd_data = {12'h000, rd_pix.c};
					end
				end
			endcase
		end
		if (rd_rise) begin
			if (st.phase == last_phase(i_bus_width)) begin
				next_st.phase = PHASE_ZERO;
				{next_st.row, next_st.col} = step_addr(st.row, st.col);
			end else begin
				next_st.phase = st.phase + PHASE_ONE;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st <= '0;
			st.sync1 <= HOST_IDLE;
			st.sync2 <= HOST_IDLE;
			st.prev_wr_n <= 1'b1;
			st.prev_rd_n <= 1'b1;
			st.seg_remap <= 1'b0;
			st.com_remap <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Frame memory; contents are undefined until written
	always_ff @(posedge i_mclk) begin
		if (ram_we) begin
			display_frame_ram[st.row][st.col] <= ram_wdata;
		end
	end

	assign scan_row = display_frame_ram[scan_ram_row];

	display_scan u_scan (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_seg_remap(st.seg_remap),
		.i_com_remap(st.com_remap),
		.i_row_pixels(scan_row),
		.o_ram_row(scan_ram_row),
		.o_row_drive(o_row_drive),
		.o_seg_drive(o_seg_drive)
	);

	assign o_data = st.rd_data;
	assign o_data_oe = st.oe;

	// ==========================================================
	// Checks
	property p_oe_needs_cs;
		@(posedge i_mclk) disable iff (!i_reset_n)
		o_data_oe |-> !$past(st.sync2.cs_n) && !$past(st.sync2.rd_n);
	endproperty
	a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("bus driven without select");

	property p_no_cs_no_we;
		@(posedge i_mclk) disable iff (!i_reset_n)
		// Judged against the pin itself, two edges back through the sync path
		ram_we |-> !$past(i_host.cs_n, 2);
	endproperty
	a_no_cs_no_we: assert property (p_no_cs_no_we) else $error("write without select");

	property p_wr18;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(wr_edge && st.sync2.dc && i_bus_width == BUS_W18)
			|=> display_frame_ram[$past(st.row)][$past(st.col)] == $past(d);
	endproperty
	a_wr18: assert property (p_wr18) else $error("18-bit pixel not stored");

	property p_bus8_three;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(ram_we && i_bus_width == BUS_W8) |-> st.phase == PHASE_TWO && ram_wdata.c == d[5:0];
	endproperty
	a_bus8_three: assert property (p_bus8_three) else $error("8-bit packing wrong");

	property p_col_step;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(ram_we && st.col != ADDR_MAX) |=> st.col == $past(st.col) + ADDR_ONE;
	endproperty
	a_col_step: assert property (p_col_step) else $error("column did not advance");

	property p_row_wrap;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(ram_we && st.col == ADDR_MAX) |=> st.col == ADDR_ZERO && st.row == $past(st.row) + ADDR_ONE;
	endproperty
	a_row_wrap: assert property (p_row_wrap) else $error("row did not wrap");

	property p_rd18;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(rd_fall && i_bus_width == BUS_W18) |=> o_data == $past(rd_pix) && o_data_oe;
	endproperty
	a_rd18: assert property (p_rd18) else $error("read data wrong");

	property p_remap_reset;
		@(posedge i_mclk) disable iff (!i_reset_n)
		!$past(i_reset_n) |-> !st.seg_remap && !st.com_remap;
	endproperty
	a_remap_reset: assert property (p_remap_reset) else $error("mirror on after reset");

	c_wr8: cover property (@(posedge i_mclk) ram_we && i_bus_width == BUS_W8);
	c_wr16: cover property (@(posedge i_mclk) ram_we && i_bus_width == BUS_W16);
	c_read: cover property (@(posedge i_mclk) rd_fall ##[1:40] rd_rise);

endmodule

// [core/display_ram_pkg.sv]
package display_ram_pkg;

	// ==========================================================
	// Geometry
	localparam int COLS = 128;
	localparam int ROWS = 128;
	localparam int CMD_ROW_BIT = 7;
	localparam logic [6:0] ADDR_ZERO = 7'h00;
	localparam logic [6:0] ADDR_ONE = 7'h01;
	localparam logic [6:0] ADDR_MAX = 7'h7F;

	// ==========================================================
	// Transfer phases and scan timing
	localparam logic [1:0] PHASE_ZERO = 2'h0;
	localparam logic [1:0] PHASE_ONE = 2'h1;
	localparam logic [1:0] PHASE_TWO = 2'h2;
	localparam logic [3:0] HOLD_ZERO = 4'h0;
	localparam logic [3:0] HOLD_ONE = 4'h1;
	localparam logic [3:0] ROW_HOLD_LAST = 4'hF;

	// ==========================================================
	// Types
	typedef struct packed {
		logic [5:0] a;
		logic [5:0] b;
		logic [5:0] c;
	} pixel_t;

	typedef pixel_t [COLS-1:0] seg_row_t;

	typedef enum logic [1:0] {BUS_W8, BUS_W16, BUS_W18} bus_width_t;

	typedef struct packed {
		logic cs_n;
		logic dc;
		logic wr_n;
		logic rd_n;
		logic [17:0] data;
	} host_pins_t;

	localparam host_pins_t HOST_IDLE = '{cs_n: 1'b1, dc: 1'b1, wr_n: 1'b1, rd_n: 1'b1,
		data: 18'h0_0000};

	typedef struct packed {
		host_pins_t sync1;
		host_pins_t sync2;
		logic prev_wr_n;
		logic prev_rd_n;
		logic [6:0] col;
		logic [6:0] row;
		logic [1:0] phase;
		pixel_t hold;
		logic [17:0] rd_data;
		logic oe;
		logic seg_remap;
		logic com_remap;
	} host_state_t;

	typedef struct packed {
		logic [6:0] phys_row;
		logic [3:0] hold;
		logic [ROWS-1:0] row_drive;
		seg_row_t seg_drive;
	} scan_state_t;

	// ==========================================================
	// Shared helpers
	function automatic logic [6:0] remap_addr(input logic [6:0] a, input logic en);
		remap_addr = en ? (ADDR_MAX - a) : a;
	endfunction

	function automatic logic [1:0] last_phase(input bus_width_t w);
		unique case (w)
			BUS_W18: last_phase = PHASE_ZERO;
			BUS_W16: last_phase = PHASE_ONE;
			default: last_phase = PHASE_TWO;
		endcase
	endfunction

endpackage

// [core/display_scan.sv]
`timescale 1ns/1ps
module display_scan (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_seg_remap,
	input wire logic i_com_remap,
	input wire display_ram_pkg::seg_row_t i_row_pixels,
	output logic [6:0] o_ram_row,
	output logic [display_ram_pkg::ROWS-1:0] o_row_drive,
	output display_ram_pkg::seg_row_t o_seg_drive
);
	import display_ram_pkg::*;

	scan_state_t st;
	scan_state_t next_st;
	logic latch;

	// ==========================================================
	// Row scan
	// Frame row read is picked by the common mirror
	assign o_ram_row = remap_addr(st.phys_row, i_com_remap);
	assign latch = (st.hold == ROW_HOLD_LAST);

	always_comb begin
		next_st = st;
		next_st.hold = st.hold + HOLD_ONE;
		if (latch) begin
			next_st.hold = HOLD_ZERO;
			next_st.row_drive = '0;
			next_st.row_drive[st.phys_row] = 1'b1;
			for (int c = 0; c < COLS; c++) begin
				next_st.seg_drive[c] = i_row_pixels[remap_addr(7'(c), i_seg_remap)];
			end
			next_st.phys_row = st.phys_row + ADDR_ONE;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_row_drive = st.row_drive;
	assign o_seg_drive = st.seg_drive;

	// ==========================================================
	// Checks
	property p_row_onehot;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(o_row_drive != '0) |-> $onehot(o_row_drive);
	endproperty
	a_row_onehot: assert property (p_row_onehot) else $error("row drive not one-hot");

	property p_seg_mirror;
		@(posedge i_mclk) disable iff (!i_reset_n)
		(latch && i_seg_remap) |=> (o_seg_drive[0] === $past(i_row_pixels[COLS-1]));
	endproperty
	a_seg_mirror: assert property (p_seg_mirror) else $error("segment mirror wrong");

	property p_row_follows;
		@(posedge i_mclk) disable iff (!i_reset_n)
		latch |=> o_row_drive[$past(st.phys_row)] ##16 o_row_drive[$past(st.phys_row, 16)];
	endproperty
	a_row_follows: assert property (p_row_follows) else $error("row drive lost");

	c_mirror_latch: cover property (@(posedge i_mclk) latch && i_seg_remap && i_com_remap);

endmodule

// [dv/host_model.sv]
`timescale 1ns/1ps
module host_model (
	input wire logic i_mclk,
	input wire logic [17:0] i_data,
	input wire logic i_oe,
	output display_ram_pkg::host_pins_t o_pins
);
	import display_ram_pkg::*;
	initial o_pins = HOST_IDLE;
	task automatic step(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	// ==========================================================
	// Strobes kept 4 clocks, past the 2-clock sync path
	task automatic wr(input logic cs_n, input logic dc, input logic [17:0] d);
		step(1);
		o_pins = '{cs_n: cs_n, dc: dc, wr_n: 1'b0, rd_n: 1'b1, data: d};
		step(4);
		o_pins.wr_n = 1'b1;
		step(4);
		// Released lines show the inverse, never a stale copy
		o_pins = '{cs_n: 1'b1, dc: 1'b1, wr_n: 1'b1, rd_n: 1'b1, data: ~d};
		step(2);
	endtask
	task automatic rd(input logic dc, output logic [18:0] q);
		step(1);
		o_pins = '{cs_n: 1'b0, dc: dc, wr_n: 1'b1, rd_n: 1'b0, data: ~o_pins.data};
		step(4);
		q = {i_oe, i_data};
		o_pins.rd_n = 1'b1;
		step(4);
		o_pins.cs_n = 1'b1;
		step(2);
	endtask
endmodule

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench;
	import display_ram_pkg::*;
	localparam pixel_t PIX_A = 18'h1_E2D4;
	localparam pixel_t PIX_B = 18'h3_0F96;
	localparam pixel_t PIX_C = 18'h0_A5B1;
	localparam pixel_t PIX_D = 18'h2_C3A7;
	localparam pixel_t PIX_E = 18'h1_5E69;
	logic mclk;
	logic reset_n;
	bus_width_t bus_width;
	logic seg_remap;
	logic com_remap;
	host_pins_t hp;
	host_pins_t pins;
	logic [17:0] data;
	logic data_oe;
	logic [ROWS-1:0] row_drive;
	seg_row_t seg_drive;
	logic [18:0] q;
	int error_cnt;
	int compares;
	// ==========================================================
	// Wire level of the shared data pins
	always_comb begin
		pins = hp;
		if (data_oe) begin
			pins.data = data;
		end
	end
	display_ram_remap_map i_dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_host(pins),
		.i_bus_width(bus_width), .i_seg_remap(seg_remap), .i_com_remap(com_remap),
		.o_data(data), .o_data_oe(data_oe), .o_row_drive(row_drive), .o_seg_drive(seg_drive));
	host_model i_host (.i_mclk(mclk), .i_data(pins.data), .i_oe(data_oe), .o_pins(hp));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// ==========================================================
	// Helpers
	task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic ptr(input logic [6:0] r, input logic [6:0] c);
		i_host.wr(1'b0, 1'b0, {10'h000, 1'b1, r});
		i_host.wr(1'b0, 1'b0, {10'h000, 1'b0, c});
	endtask
	task automatic rdchk(input string name, input logic [17:0] exp);
		i_host.rd(1'b1, q);
		chk(name, q[17:0], exp);
		chk("read_oe", q[18], 1'b1);
	endtask
	// Mirror change only trusted from a fresh latch of the row
	task automatic look(input logic s, input logic c_m, input int r, input int c, input pixel_t e);
		int n;
		n = 0;
		@(posedge mclk);
		#1;
		seg_remap = s;
		com_remap = c_m;
		// Mirror bits are registered; a latch on the next edge still uses old ones
		repeat (2) @(posedge mclk);
		#1;
		while (row_drive[r] !== 1'b0 && n < 5000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		while (row_drive[r] !== 1'b1 && n < 5000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		chk("look_time", n < 5000, 1'b1);
		chk("row_onehot", row_drive === (128'h1 << r), 1'b1);
		chk("seg_pixel", seg_drive[c], e);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		chk("oe", data_oe, 1'b0);
		chk("data", data, 18'h0_0000);
		chk("rows", |row_drive, 1'b0);
	endtask
	task automatic t_w18();
		ptr(7'h7F, 7'h7F);
		i_host.wr(1'b0, 1'b1, PIX_A);
		i_host.wr(1'b0, 1'b1, PIX_B);
		i_host.wr(1'b0, 1'b1, PIX_C);
		ptr(7'h7F, 7'h7F);
		rdchk("last_cell", PIX_A);
		rdchk("wrap_cell", PIX_B);
		rdchk("next_cell", PIX_C);
	endtask
	task automatic t_cs();
		ptr(7'h00, 7'h00);
		i_host.wr(1'b1, 1'b1, ~PIX_B);
		rdchk("no_cs_write", PIX_B);
		i_host.rd(1'b0, q);
		chk("cmd_read_oe", q[18], 1'b0);
		rdchk("after_cmd_read", PIX_C);
	endtask
	task automatic t_w16();
		bus_width = BUS_W16;
		ptr(7'h01, 7'h00);
		i_host.wr(1'b0, 1'b1, {6'h2A, PIX_D.a, PIX_D.b});
		i_host.wr(1'b0, 1'b1, {12'hFFF, PIX_D.c});
		ptr(7'h01, 7'h00);
		rdchk("w16_ab", {6'h00, PIX_D.a, PIX_D.b});
		rdchk("w16_c", {12'h000, PIX_D.c});
	endtask
	task automatic t_w8();
		bus_width = BUS_W8;
		ptr(7'h01, 7'h01);
		i_host.wr(1'b0, 1'b1, {12'hABC, PIX_E.a});
		i_host.wr(1'b0, 1'b1, {12'h5D3, PIX_E.b});
		i_host.wr(1'b0, 1'b1, {12'hF0F, PIX_E.c});
		bus_width = BUS_W18;
		ptr(7'h01, 7'h01);
		rdchk("w8_pixel", PIX_E);
	endtask
	task automatic t_mirror();
		look(1'b0, 1'b0, 0, 0, PIX_B);
		look(1'b0, 1'b0, 127, 127, PIX_A);
		look(1'b1, 1'b0, 0, 127, PIX_B);
		look(1'b1, 1'b0, 1, 126, PIX_E);
		look(1'b0, 1'b1, 127, 1, PIX_C);
		look(1'b0, 1'b1, 126, 0, PIX_D);
		look(1'b1, 1'b1, 0, 0, PIX_A);
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		reset_n = 1'b0;
		bus_width = BUS_W18;
		seg_remap = 1'b0;
		com_remap = 1'b0;
		error_cnt = 0;
		compares = 0;
		repeat (10) @(posedge mclk);
		#1;
		reset_n = 1'b1;
		t_reset();
		t_w18();
		t_cs();
		t_w16();
		t_w8();
		t_mirror();
		end_sim();
	end
	initial begin
		#300000;
		error_cnt++;
		end_sim();
	end
endmodule
